// [logic/uart_frame_mode_config.sv]
/*
 Frame and mode configuration of a paired UART, with a transmit data
 FIFO in front of the frame engine, reached over Avalon-MM.
 Assumes the frame engine sits on the same clock, and that the four
 receive pins are asynchronous and are synchronised here.
*/
// The Avalon-MM slave port was decided locally.
`include "uart_frame_mode_defines.svh"

// Plain FIFO; depth must be a power of two
module frame_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                     clk_in,
   input  wire logic                     resetn_in,
   input  wire logic                     in_valid_in,
   output logic                          in_ready_out,
   input  wire logic [WIDTH-1:0]         in_data_in,
   output logic                          out_valid_out,
   input  wire logic                     out_ready_in,
   output logic [WIDTH-1:0]              out_data_out,
   output logic [$clog2(DEPTH):0]        count_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];        // Storage
   logic [AW:0]      wr_ptr_q;           // Write pointer with wrap bit
   logic [AW:0]      rd_ptr_q;           // Read pointer with wrap bit
   wire logic        push;
   wire logic        pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready_out  = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
   assign out_valid_out = wr_ptr_q != rd_ptr_q;
   assign out_data_out  = mem[rd_ptr_q[AW-1:0]];
   assign count_out     = wr_ptr_q - rd_ptr_q;
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // Storage has no reset; only pointers carry state
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem[wr_ptr_q[AW-1:0]] <= in_data_in;
      end
   end

   // Pointer update
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
         rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
      end
   end
endmodule // frame_fifo

// What this block does
// - Paired full duplex ignores channel-1 mode registers
// - Sample point: half baud count, minus one when selected
// - Route one of four pins to receive
// - Baud clock: low, high or PLL clock
// - Channel-1 direction: 0 transmit, 1 receive
// - Channel-0 bit order: LSB or MSB first
// - Channel-0 line polarity positive or inverted
// - Channel-0 one or two stop bits
// - Channel-0 parity even, odd or none
// - Channel-0 length eight, seven, six, five
// - Channel-1 order, polarity, stop as channel 0
// - Channel-1 parity even, odd or none
// - Channel-1 length eight, seven, six, five
// - Full duplex: channel 0 receives, 1 transmits
module uart_frame_mode_config #(
   parameter int FIFO_DEPTH = 16,   // Transmit FIFO entries
   parameter int BAUD_W     = 12    // Baud count width
) (
   input  wire logic              CLK_IN,
   input  wire logic              RESETN_IN,
   input  wire logic [15:0]       AVS_ADDRESS_IN,
   input  wire logic              AVS_READ_IN,
   input  wire logic              AVS_WRITE_IN,
   input  wire logic [7:0]        AVS_WRITEDATA_IN,
   output logic [7:0]             AVS_READDATA_OUT,
   output logic                   AVS_WAITREQUEST_OUT,
   input  wire logic [BAUD_W-1:0] BAUD_COUNT_IN,
   input  wire logic [3:0]        RX_PIN_IN,
   input  wire logic              TX_READY_IN,
   output logic [7:0]             TX_DATA_OUT,
   output logic                   TX_VALID_OUT,
   output logic                   CHAN0_MSB_FIRST_OUT,
   output logic                   CHAN0_INVERT_OUT,
   output logic                   CHAN0_TWO_STOP_OUT,
   output logic                   CHAN0_PARITY_EN_OUT,
   output logic                   CHAN0_PARITY_ODD_OUT,
   output logic [3:0]             CHAN0_DATA_BITS_OUT,
   output logic                   CHAN0_RX_MODE_OUT,
   output logic                   CHAN1_MSB_FIRST_OUT,
   output logic                   CHAN1_INVERT_OUT,
   output logic                   CHAN1_TWO_STOP_OUT,
   output logic                   CHAN1_PARITY_EN_OUT,
   output logic                   CHAN1_PARITY_ODD_OUT,
   output logic [3:0]             CHAN1_DATA_BITS_OUT,
   output logic                   CHAN1_RX_MODE_OUT,
   output logic [2:0]             CHAN1_CLK_SEL_OUT,
   output logic [BAUD_W-1:0]      CHAN1_SAMPLE_POINT_OUT,
   output logic                   CHAN1_RX_OUT
);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;

   // Software registers
   logic [7:0] frame0_q;        // Channel-0 frame format
   logic [7:0] mode1_q;         // Channel-1 routing and mode
   logic [7:0] frame1_q;        // Channel-1 frame format
   logic [7:0] pair_q;          // Pairing and channel-0 direction
   logic       wait_q;          // Waitrequest, high while idle
   logic [7:0] rdata_q;         // Read data

   // Decoded, registered outputs
   uart_frame_mode_pkg::frame_fmt_t fmt0_q;
   uart_frame_mode_pkg::frame_fmt_t fmt1_q;
   uart_frame_mode_pkg::baud_clk_t  clk_sel_q;
   logic              dir0_q;         // Channel 0 receives
   logic              dir1_q;         // Channel 1 receives
   logic [BAUD_W-1:0] sample_q;       // Sample point count
   logic              rx_q;           // Routed receive level

   // Receive pin synchronisers
   logic [3:0] rx_meta_q;       // First stage, read by second only
   logic [3:0] rx_sync_q;       // Second stage

   // Transmit path
   logic [7:0] tx_data_q;
   logic       tx_valid_q;

   // Decodes a frame register into a format
   function automatic uart_frame_mode_pkg::frame_fmt_t decode_frame(
      input logic [7:0] r);
      uart_frame_mode_pkg::frame_fmt_t f;
      f.msb_first  = r[`FRM_BIT_ORDER];
      f.invert     = r[`FRM_INVERT];
      f.two_stop   = r[`FRM_STOP_LEN];
      f.parity_en  = ~r[`FRM_PARITY_HI];
      f.parity_odd = ~r[`FRM_PARITY_HI] & r[`FRM_PARITY_LO];
      // Codes 00..11 give 8..5 bits
      f.data_bits  = 4'h8 - {2'h0, r[`FRM_LEN_HI:`FRM_LEN_LO]};
      return f;
   endfunction

   // Address decode
   wire logic hit_f0   = AVS_ADDRESS_IN == `IDX_CHAN0_FRAME;
   wire logic hit_m1   = AVS_ADDRESS_IN == `IDX_CHAN1_MODE;
   wire logic hit_f1   = AVS_ADDRESS_IN == `IDX_CHAN1_FRAME;
   wire logic hit_pair = AVS_ADDRESS_IN == `IDX_PAIR_CTRL;
   wire logic hit_tx   = AVS_ADDRESS_IN == `IDX_TX_DATA;
   wire logic hit_stat = AVS_ADDRESS_IN == `IDX_FIFO_STATUS;

   // FIFO wiring
   wire logic          fifo_in_ready;
   wire logic          fifo_out_valid;
   wire logic [7:0]    fifo_out_data;
   wire logic [CW-1:0] fifo_count;
   wire logic          load_out = ~tx_valid_q | TX_READY_IN;

   // Bus handshake; a data write stalls while the FIFO is full
   wire logic req       = AVS_READ_IN | AVS_WRITE_IN;
   wire logic accept_ok = ~hit_tx | fifo_in_ready | AVS_READ_IN;
   wire logic wait_d    = ~(req & wait_q & accept_ok);
   wire logic commit_wr = AVS_WRITE_IN & ~wait_q;
   wire logic fifo_push = commit_wr & hit_tx;

   // Status word: output busy, full, empty, fill level
   wire logic [7:0] status = 8'({tx_valid_q, ~fifo_in_ready,
                                 ~fifo_out_valid, fifo_count});

   // Read selection; registers hold zeros in reserved bits
   wire logic [7:0] rd_value =
      hit_f0   ? frame0_q :
      hit_m1   ? mode1_q  :
      hit_f1   ? frame1_q :
      hit_pair ? pair_q   :
      hit_stat ? status   :
                 8'h00;                           // Unmapped or write-only

   // Pairing: in full duplex channel-1 registers are ignored
   wire logic half = pair_q[`PAIR_HALF_DUPLEX];
   wire logic [7:0] frame1_eff = half ? frame1_q : frame0_q;
   wire logic [7:0] mode1_eff  = half ? mode1_q  : `MODE_RESET;
   wire logic dir0_d = half ? pair_q[`PAIR_CHAN0_DIR] : 1'b1;
   wire logic dir1_d = mode1_eff[`MOD_DIRECTION];

   // Baud clock choice; the forbidden code falls back to low speed
   wire logic [1:0] clk_code = mode1_eff[`MOD_CLK_HI:`MOD_CLK_LO];
   wire uart_frame_mode_pkg::baud_clk_t clk_sel_d =
      (clk_code == 2'h2) ? uart_frame_mode_pkg::CLK_HIGH_SPEED :
      (clk_code == 2'h3) ? uart_frame_mode_pkg::CLK_PLL :
                           uart_frame_mode_pkg::CLK_LOW_SPEED;

   // Sample point: count/2, or count/2-1 when selected
   wire logic [BAUD_W-1:0] sample_d = (BAUD_COUNT_IN >> 1)
      - BAUD_W'(mode1_eff[`MOD_SAMPLE_SEL]);

   // Routed receive pin, inverted for negative logic; idle in full duplex
   wire logic [1:0] route = mode1_eff[`MOD_ROUTE_HI:`MOD_ROUTE_LO];
   wire uart_frame_mode_pkg::frame_fmt_t fmt1_d = decode_frame(frame1_eff);
   wire logic rx_d = half ? (rx_sync_q[route] ^ fmt1_d.invert) : 1'b1;

   // Transmit format follows whichever channel transmits
   wire uart_frame_mode_pkg::frame_fmt_t fmt0_d = decode_frame(frame0_q);
   wire logic [1:0] tx_len = (half & dir1_d) ? frame0_q[1:0] : frame1_eff[1:0];
   wire logic       tx_msb = (half & dir1_d) ? fmt0_d.msb_first
                                             : fmt1_d.msb_first;
   wire logic [7:0] tx_masked = fifo_out_data & (8'hFF >> tx_len);
   wire logic [7:0] tx_rev;
   wire logic [7:0] tx_fmt;

   // Bit reversal so the frame engine always shifts bit 0 first
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_rev
         assign tx_rev[i] = tx_masked[7-i];
      end
   endgenerate

   // Reversed word is realigned to the character length
   assign tx_fmt = tx_msb ? (tx_rev >> tx_len) : tx_masked;

   frame_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (CLK_IN),
      .resetn_in     (RESETN_IN),
      .in_valid_in   (fifo_push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (AVS_WRITEDATA_IN),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (load_out),
      .out_data_out  (fifo_out_data),
      .count_out     (fifo_count)
   );

   // Bus handshake and read data
   always_ff @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         wait_q  <= 1'b1;
         rdata_q <= 8'h00;
      end
      else
      begin
         wait_q  <= wait_d;
         rdata_q <= rd_value;
      end
   end

   // Register writes; settings are meant to change only while stopped,
   // and nothing here guards against a change mid-character
   always_ff @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         frame0_q <= `FRAME_RESET;
         mode1_q  <= `MODE_RESET;
         frame1_q <= `FRAME_RESET;
         pair_q   <= `PAIR_RESET;
      end
      else if (commit_wr)
      begin
         if (hit_f0)
         begin
            frame0_q <= AVS_WRITEDATA_IN & `FRAME_WR_MASK;
         end
         if (hit_m1)
         begin
            mode1_q <= AVS_WRITEDATA_IN & `MODE_WR_MASK;
         end
         if (hit_f1)
         begin
            frame1_q <= AVS_WRITEDATA_IN & `FRAME_WR_MASK;
         end
         if (hit_pair)
         begin
            pair_q <= AVS_WRITEDATA_IN & `PAIR_WR_MASK;
         end
      end
   end

   // Decoded configuration outputs
   always_ff @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         fmt0_q    <= uart_frame_mode_pkg::FMT_RESET;
         fmt1_q    <= uart_frame_mode_pkg::FMT_RESET;
         clk_sel_q <= uart_frame_mode_pkg::CLK_LOW_SPEED;
         dir0_q    <= 1'b1;
         dir1_q    <= 1'b0;
         sample_q  <= '0;
      end
      else
      begin
         fmt0_q    <= fmt0_d;
         fmt1_q    <= fmt1_d;
         clk_sel_q <= clk_sel_d;
         dir0_q    <= dir0_d;
         dir1_q    <= dir1_d;
         sample_q  <= sample_d;
      end
   end

   // Receive pin synchroniser and routing
   always_ff @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         rx_meta_q <= 4'hF;
         rx_sync_q <= 4'hF;
         rx_q      <= 1'b1;
      end
      else
      begin
         rx_meta_q <= RX_PIN_IN;
         rx_sync_q <= rx_meta_q;
         rx_q      <= rx_d;
      end
   end

   // Output holding stage toward the frame engine
   always_ff @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         tx_valid_q <= 1'b0;
         tx_data_q  <= 8'h00;
      end
      else if (load_out)
      begin
         tx_valid_q <= fifo_out_valid;
         // Keep the last word while empty, so an unwritten entry never leaks out
         tx_data_q  <= fifo_out_valid ? tx_fmt : tx_data_q;
      end
   end

   // Port mapping, all from flip-flops
   assign AVS_WAITREQUEST_OUT    = wait_q;
   assign AVS_READDATA_OUT       = rdata_q;
   assign TX_DATA_OUT            = tx_data_q;
   assign TX_VALID_OUT           = tx_valid_q;
   assign CHAN0_MSB_FIRST_OUT    = fmt0_q.msb_first;
   assign CHAN0_INVERT_OUT       = fmt0_q.invert;
   assign CHAN0_TWO_STOP_OUT     = fmt0_q.two_stop;
   assign CHAN0_PARITY_EN_OUT    = fmt0_q.parity_en;
   assign CHAN0_PARITY_ODD_OUT   = fmt0_q.parity_odd;
   assign CHAN0_DATA_BITS_OUT    = fmt0_q.data_bits;
   assign CHAN0_RX_MODE_OUT      = dir0_q;
   assign CHAN1_MSB_FIRST_OUT    = fmt1_q.msb_first;
   assign CHAN1_INVERT_OUT       = fmt1_q.invert;
   assign CHAN1_TWO_STOP_OUT     = fmt1_q.two_stop;
   assign CHAN1_PARITY_EN_OUT    = fmt1_q.parity_en;
   assign CHAN1_PARITY_ODD_OUT   = fmt1_q.parity_odd;
   assign CHAN1_DATA_BITS_OUT    = fmt1_q.data_bits;
   assign CHAN1_RX_MODE_OUT      = dir1_q;
   assign CHAN1_CLK_SEL_OUT      = clk_sel_q;
   assign CHAN1_SAMPLE_POINT_OUT = sample_q;
   assign CHAN1_RX_OUT           = rx_q;

   // A request and its one-cycle answer
   sequence s_req_ctrl;
      req & ~hit_tx & wait_q;
   endsequence
   sequence s_ack;
      ~AVS_WAITREQUEST_OUT;
   endsequence

   // Register accesses answer in the next cycle
   chk_bus_answer: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      s_req_ctrl |=> s_ack ##1 AVS_WAITREQUEST_OUT)
      else $error("register access not answered in one cycle");

   // Full duplex forces directions and ignores channel-1 registers
   chk_full_dir: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ~half |=> CHAN0_RX_MODE_OUT & ~CHAN1_RX_MODE_OUT)
      else $error("full duplex directions wrong");

   chk_full_ignore: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ~half |=> CHAN1_DATA_BITS_OUT == CHAN0_DATA_BITS_OUT
                && CHAN1_CLK_SEL_OUT == 3'b001)
      else $error("channel-1 registers act in full duplex");

   chk_sample_pt: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      half |=> CHAN1_SAMPLE_POINT_OUT == ($past(BAUD_COUNT_IN) >> 1)
               - BAUD_W'($past(mode1_q[`MOD_SAMPLE_SEL])))
      else $error("sample point wrong");

   chk_rx_route: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      half |=> CHAN1_RX_OUT == ($past(rx_sync_q[route]) ^ $past(fmt1_d.invert)))
      else $error("receive routing wrong");

   chk_clk_select: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      half && mode1_q[2:1] == 2'h3 |=> CHAN1_CLK_SEL_OUT == 3'b100)
      else $error("pll clock not selected");

   chk_direction: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      half |=> CHAN1_RX_MODE_OUT == $past(mode1_q[`MOD_DIRECTION]))
      else $error("channel-1 direction wrong");

   chk_char_len: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      frame0_q[1:0] == 2'h3 |=> CHAN0_DATA_BITS_OUT == 4'h5)
      else $error("five-bit length not decoded");

   chk_parity_none: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      frame0_q[`FRM_PARITY_HI] |=> ~CHAN0_PARITY_EN_OUT & ~CHAN0_PARITY_ODD_OUT)
      else $error("parity not disabled");

   chk_order_stop: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      1'b1 |=> CHAN0_TWO_STOP_OUT == $past(frame0_q[`FRM_STOP_LEN])
               && CHAN0_MSB_FIRST_OUT == $past(frame0_q[`FRM_BIT_ORDER]))
      else $error("stop length or bit order wrong");

   chk_reserved_zero: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ~AVS_WAITREQUEST_OUT && $past(hit_m1 & AVS_READ_IN)
      |-> AVS_READDATA_OUT[7] == 1'b0 && AVS_READDATA_OUT[3] == 1'b0)
      else $error("reserved bit reads one");
endmodule // uart_frame_mode_config

// [logic/uart_frame_mode_defines.svh]
/*
 Register indices, field positions, write masks and reset values of the
 UART frame and mode configuration block.
 Assumes it is included once per compile unit by its bare name.
*/
`ifndef UART_FRAME_MODE_DEFINES_SVH
`define UART_FRAME_MODE_DEFINES_SVH

// Word indices on the bus (byte address equals the index, as each word is one byte)
`define IDX_CHAN0_FRAME   16'hF713
`define IDX_CHAN1_MODE    16'hF71A
`define IDX_CHAN1_FRAME   16'hF71B
`define IDX_PAIR_CTRL     16'hF720
`define IDX_TX_DATA       16'hF721
`define IDX_FIFO_STATUS   16'hF722

// Frame format register fields
`define FRM_BIT_ORDER     6
`define FRM_INVERT        5
`define FRM_STOP_LEN      4
`define FRM_PARITY_HI     3
`define FRM_PARITY_LO     2
`define FRM_LEN_HI        1
`define FRM_LEN_LO        0

// Routing and mode register fields
`define MOD_SAMPLE_SEL    6
`define MOD_ROUTE_HI      5
`define MOD_ROUTE_LO      4
`define MOD_CLK_HI        2
`define MOD_CLK_LO        1
`define MOD_DIRECTION     0

// Pair control register fields
`define PAIR_HALF_DUPLEX  0
`define PAIR_CHAN0_DIR    1

// Writable bits; all others are reserved and read as zero
`define FRAME_WR_MASK     8'h7F
`define MODE_WR_MASK      8'h77
`define PAIR_WR_MASK      8'h03

// Reset values
`define FRAME_RESET       8'h00
`define MODE_RESET        8'h00
`define PAIR_RESET        8'h00

`endif

// [logic/uart_frame_mode_pkg.sv]
/*
 Types shared by the UART frame and mode configuration block.
 Assumes nothing of its surroundings.
*/
package uart_frame_mode_pkg;

   // Decoded frame format of one channel
   typedef struct packed {
      logic       msb_first;   // Bit order
      logic       invert;      // Negative line logic
      logic       two_stop;    // Two stop bits
      logic       parity_en;   // Parity bit present
      logic       parity_odd;  // Odd parity when present
      logic [3:0] data_bits;   // Character length 5..8
   } frame_fmt_t;

   // One-hot baud generator clock choice
   typedef enum logic [2:0] {
      CLK_LOW_SPEED  = 3'b001,
      CLK_HIGH_SPEED = 3'b010,
      CLK_PLL        = 3'b100
   } baud_clk_t;

   // Format that a cleared register decodes to
   localparam frame_fmt_t FMT_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h8};

endpackage

// [verification/test_uart_frame_mode_config.sv]
/*
 Self-checking bench of the frame and mode configuration block.
 Assumes the design files and the defines header are compiled first.
*/
`include "uart_frame_mode_defines.svh"
module test_uart_frame_mode_config;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, resetn, rd, wr, wait_req, stall, tx_ready, tx_valid, done18;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, tx_data;
   logic [11:0] baud, sample;
   logic [3:0]  level, pins, b0, b1;
   logic [2:0]  clk_sel;
   logic        m0, i0, s0, p0, o0, rx0, m1, i1, s1, p1, o1, rx1, c1rx;
   logic [7:0]  seen [32];
   logic [5:0]  seen_cnt;
   int          num_errors, checks_done;
   wire  [8:0]  fmt0 = {m0, i0, s0, p0, o0, b0};  // Decoded channel-0 format
   wire  [8:0]  fmt1 = {m1, i1, s1, p1, o1, b1};  // Decoded channel-1 format

   uart_frame_mode_config #(.FIFO_DEPTH(16), .BAUD_W(12)) u_dut (
      .CLK_IN(clk), .RESETN_IN(resetn), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
      .AVS_WAITREQUEST_OUT(wait_req), .BAUD_COUNT_IN(baud), .RX_PIN_IN(pins),
      .TX_READY_IN(tx_ready), .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid),
      .CHAN0_MSB_FIRST_OUT(m0), .CHAN0_INVERT_OUT(i0), .CHAN0_TWO_STOP_OUT(s0),
      .CHAN0_PARITY_EN_OUT(p0), .CHAN0_PARITY_ODD_OUT(o0), .CHAN0_DATA_BITS_OUT(b0),
      .CHAN0_RX_MODE_OUT(rx0), .CHAN1_MSB_FIRST_OUT(m1), .CHAN1_INVERT_OUT(i1),
      .CHAN1_TWO_STOP_OUT(s1), .CHAN1_PARITY_EN_OUT(p1), .CHAN1_PARITY_ODD_OUT(o1),
      .CHAN1_DATA_BITS_OUT(b1), .CHAN1_RX_MODE_OUT(rx1), .CHAN1_CLK_SEL_OUT(clk_sel),
      .CHAN1_SAMPLE_POINT_OUT(sample), .CHAN1_RX_OUT(c1rx));

   uart_line_partner u_partner (.clk_in(clk), .resetn_in(resetn), .stall_in(stall),
      .line_level_in(level), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
      .tx_ready_out(tx_ready), .rx_pins_out(pins), .seen_out(seen),
      .seen_count_out(seen_cnt));

   // Expected decode of a frame format byte, worked out independently
   function automatic logic [8:0] fmt(input logic [7:0] v);
      return {v[6], v[5], v[4], ~v[3], ~v[3] & v[2], 4'h8 - {2'b00, v[1:0]}};
   endfunction

   // Compare and count; a mismatch is reported at once
   task automatic check(input string name, input logic [15:0] seen_v, input logic [15:0] exp);
      checks_done++;
      if (seen_v !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen_v);
      end
   endtask

   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic is_wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      rd    <= ~is_wr;
      wr    <= is_wr;
      // Waitrequest and read data are taken at the same rising edge
      @(posedge clk);
      while (wait_req !== 1'b0)
         @(posedge clk);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check(n, q, exp);
   endtask

   // Let the commit and the one-clock output lag land
   task automatic settle();
      repeat (4) @(negedge clk);
   endtask

   // Reset values, unmapped place, full-duplex pairing after reset
   task automatic test_reset();
      rchk("frame0 reset", `IDX_CHAN0_FRAME, 8'h00);
      rchk("mode1 reset", `IDX_CHAN1_MODE, 8'h00);
      rchk("frame1 reset", `IDX_CHAN1_FRAME, 8'h00);
      wreg(16'h0000, 8'hFF);
      rchk("unmapped", 16'h0000, 8'h00);
      rchk("tx data read", `IDX_TX_DATA, 8'h00);
      check("fmt0 reset", fmt0, fmt(8'h00));
      check("chan0 rx", rx0, 1'b1);
      check("chan1 rx", rx1, 1'b0);
      check("clk sel", clk_sel, 3'b001);
   endtask

   // Seven channel-0 codes; channel 1 follows each in full duplex
   task automatic test_chan0_format();
      logic [7:0] v [7] = '{8'h00, 8'h41, 8'h22, 8'h17, 8'h6A, 8'h0C, 8'hFF};
      foreach (v[k])
      begin
         wreg(`IDX_CHAN0_FRAME, v[k]);
         settle();
         check("fmt0", fmt0, fmt(v[k] & 8'h7F));
         check("fmt1 paired", fmt1, fmt(v[k] & 8'h7F));
         rchk("frame0 back", `IDX_CHAN0_FRAME, v[k] & 8'h7F);
      end
   endtask

   // Half duplex: routing, clock, direction, sample point, channel-1 format
   task automatic test_half_duplex();
      logic [1:0] ck [4] = '{2'b00, 2'b10, 2'b11, 2'b00};
      logic [2:0] hot [4] = '{3'b001, 3'b010, 3'b100, 3'b001};
      logic [7:0] v [5] = '{8'h41, 8'h22, 8'h17, 8'h6A, 8'hFF};
      wreg(`IDX_PAIR_CTRL, 8'h03);
      settle();
      check("chan0 rx half", rx0, 1'b1);
      wreg(`IDX_PAIR_CTRL, 8'h01);
      settle();
      check("chan0 tx half", rx0, 1'b0);
      for (int c = 0; c < 4; c++)
      begin
         // Written only while no transfer runs
         wreg(`IDX_CHAN1_MODE, {1'b0, c[0], c[1:0], 1'b0, ck[c], c[1]});
         level <= 4'h1 << c;
         settle();
         check("route high", c1rx, 1'b1);
         @(posedge clk);
         level <= ~(4'h1 << c);
         settle();
         check("route low", c1rx, 1'b0);
         check("clk sel", clk_sel, hot[c]);
         check("direction", rx1, c[1]);
         check("sample", sample, 12'h07F - {11'h000, c[0]});
      end
      wreg(`IDX_CHAN1_MODE, 8'hFF);
      rchk("mode1 back", `IDX_CHAN1_MODE, 8'h77);
      foreach (v[k])
      begin
         // Written only while stopped
         wreg(`IDX_CHAN1_FRAME, v[k]);
         settle();
         check("fmt1", fmt1, fmt(v[k] & 8'h7F));
         check("fmt0 kept", fmt0, fmt(8'h7F));
      end
   endtask

   // Back to full duplex: channel-1 registers lose their effect
   task automatic test_full_duplex();
      wreg(`IDX_PAIR_CTRL, 8'h00);
      wreg(`IDX_CHAN0_FRAME, 8'h00);  // Written while stopped
      settle();
      check("fmt1 full", fmt1, fmt(8'h00));
      check("clk full", clk_sel, 3'b001);
      check("sample full", sample, 12'h07F);
      check("rx line full", c1rx, 1'b1);
      check("chan1 tx", rx1, 1'b0);
      check("chan0 rx", rx0, 1'b1);
      rchk("mode1 kept", `IDX_CHAN1_MODE, 8'h77);
   endtask

   // Fill the FIFO while the engine stalls, refuse one, then drain in order
   task automatic test_fifo();
      wreg(`IDX_CHAN0_FRAME, 8'h03);
      stall <= 1'b1;
      for (int i = 0; i < 17; i++)
         wreg(`IDX_TX_DATA, 8'hA0 + i[7:0]);
      rchk("status full", `IDX_FIFO_STATUS, 8'hD0);
      fork
         begin
            wreg(`IDX_TX_DATA, 8'hC5);
            done18 = 1'b1;
         end
         begin
            repeat (10) @(negedge clk);
            check("refused", done18, 1'b0);
            @(posedge clk);
            stall <= 1'b0;
         end
      join
      for (int t = 0; t < 100 && seen_cnt != 6'd18; t++)
         @(negedge clk);
      for (int i = 0; i < 18; i++)
         check("tx char", seen[i], (i < 17 ? 8'hA0 + i[7:0] : 8'hC5) & 8'h1F);
      rchk("status empty", `IDX_FIFO_STATUS, 8'h20);
   endtask

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Free-running clock, 25 ns period
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Cut a hang short; the whole run needs well under this
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      {resetn, rd, wr, stall, done18} = 5'b00000;
      addr  = 16'h0000;
      wdata = 8'h00;
      baud  = 12'h0FF;
      level = 4'hF;
      num_errors  = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      test_reset();
      test_chan0_format();
      test_half_duplex();
      test_full_duplex();
      test_fifo();
      finish_test();
   end
endmodule // test_uart_frame_mode_config

// [verification/uart_line_partner.sv]
/*
 Behavioural far side of the block: the frame engine that takes formatted
 characters, and the remote sender that sets the four receive pins.
 Assumes one clock shared with the block and a synchronous active-low reset.
*/
module uart_line_partner (
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic       stall_in,       // Engine busy, hold ready low
   input  wire logic [3:0] line_level_in,  // Levels the remote sender drives
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   output logic            tx_ready_out,
   output logic [3:0]      rx_pins_out,
   output logic [7:0]      seen_out [32],
   output logic [5:0]      seen_count_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // Ready drops while stalled, so slow answers are possible
   assign tx_ready_out = ~stall_in;
   // The remote sender always drives its line, no release between frames
   assign rx_pins_out = line_level_in;

   // Record every character taken, in order
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         seen_count_out <= 6'h00;
      else if (tx_valid_in && tx_ready_out)
      begin
         seen_out[seen_count_out[4:0]] <= tx_data_in;
         seen_count_out                <= seen_count_out + 6'h01;
      end
   end
endmodule // uart_line_partner
